// *** iolp_output_port.sv ***
// Isolated output latch port: I/O-space byte registers and output groups
//
// Function
// - Decode eight consecutive byte registers in host I/O space from the base.
// - Base sits on an eight-byte boundary; only three low bits pick a register.
// - Base may lie anywhere in the full 16-bit I/O address space.
// - Offsets 0,1 group A; 2,4 group B; 5,6 group C; 3,7 unused.
// - A written one turns an output on, a zero turns it off.
// - A read returns the latched output state of the addressed byte.
// - Fixed vendor and device codes are shown in configuration space.
// - Base address comes only from host configuration, never from straps.
// - No user options; behaviour fixed except assigned base and outputs.
// - All outputs clear to off at power-up and on system reset.
`timescale 1ns/10ps
`default_nettype none
`include "iolp_params.svh"

module iolp_output_port
#(
   parameter int ADDR_W = `IOLP_IO_ADDR_BITS,
   parameter logic [15:0] VENDOR_ID = `IOLP_CFG_VENDOR_ID, // Arbitrary value
   parameter logic [15:0] DEVICE_ID = `IOLP_CFG_DEVICE_ID  // Arbitrary value
)
(
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   input  wire logic                 cfg_base_wr,
   input  wire logic [ADDR_W-1:0]    cfg_base_data,
   input  wire logic                 io_wr,
   input  wire logic                 io_rd,
   input  wire logic [ADDR_W-1:0]    io_addr,
   input  wire iolp_pkg::iolp_byte_t io_wdata,
   output var  iolp_pkg::iolp_byte_t io_rdata,
   output var  logic                 io_hit,
   output var  logic [15:0]          cfg_vendor_id,
   output var  logic [15:0]          cfg_device_id,
   output var  logic [ADDR_W-1:0]    cfg_base_q,
   output var  logic [15:0]          group_a_out,
   output var  logic [15:0]          group_b_out,
   output var  logic [15:0]          group_c_out
);

   logic                 sel;
   iolp_pkg::iolp_offset_t off;
   logic [5:0]           wr_en;
   iolp_pkg::iolp_byte_t lat [6];
   iolp_pkg::iolp_byte_t next_rdata;

   // ------------------------------------------------------------
   // Base address, set by host configuration only
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         cfg_base_q <= '0;
      else if (cfg_base_wr)
         cfg_base_q <= {cfg_base_data[ADDR_W-1:`IOLP_WINDOW_BITS],
                        3'h0};
   end

   // Identity codes are constants; only the base is configurable
   always_ff @(posedge clk)
   begin
      cfg_vendor_id <= VENDOR_ID;
      cfg_device_id <= DEVICE_ID;
   end

   // ------------------------------------------------------------
   // Window decode
   // ------------------------------------------------------------
   // Full-width compare of the upper bits covers the whole 64K space
   assign sel = (io_addr[ADDR_W-1:`IOLP_WINDOW_BITS] ==
                 cfg_base_q[ADDR_W-1:`IOLP_WINDOW_BITS]);
   assign off = io_addr[`IOLP_WINDOW_BITS-1:0];

   always_comb
   begin
      wr_en = 6'h00;
      if (io_wr && sel)
      begin
         unique case (off)
            `IOLP_OFF_GROUP_A_LOW:  wr_en = 6'h01;
            `IOLP_OFF_GROUP_A_HIGH: wr_en = 6'h02;
            `IOLP_OFF_GROUP_B_LOW:  wr_en = 6'h04;
            `IOLP_OFF_GROUP_B_HIGH: wr_en = 6'h08;
            `IOLP_OFF_GROUP_C_LOW:  wr_en = 6'h10;
            `IOLP_OFF_GROUP_C_HIGH: wr_en = 6'h20;
            `IOLP_OFF_UNUSED_THREE,
            `IOLP_OFF_UNUSED_SEVEN: wr_en = 6'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Output latches
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 6; g++)
      begin : g_latch
         iolp_byte_latch u_latch
         (
            .clk     (clk),
            .rst_b   (rst_b),
            .wr_en   (wr_en[g]),
            .wr_data (io_wdata),
            .latch_q (lat[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Readback
   // ------------------------------------------------------------
   always_comb
   begin
      unique case (off)
         `IOLP_OFF_GROUP_A_LOW:  next_rdata = lat[0];
         `IOLP_OFF_GROUP_A_HIGH: next_rdata = lat[1];
         `IOLP_OFF_GROUP_B_LOW:  next_rdata = lat[2];
         `IOLP_OFF_GROUP_B_HIGH: next_rdata = lat[3];
         `IOLP_OFF_GROUP_C_LOW:  next_rdata = lat[4];
         `IOLP_OFF_GROUP_C_HIGH: next_rdata = lat[5];
         `IOLP_OFF_UNUSED_THREE,
         `IOLP_OFF_UNUSED_SEVEN: next_rdata = `IOLP_UNUSED_READ;
      endcase
   end

   // Read data registered; valid the cycle after io_rd
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         io_rdata <= 8'h00;
         io_hit   <= 1'b0;
      end
      else
      begin
         io_hit   <= sel && (io_rd || io_wr);
         io_rdata <= (io_rd && sel) ? next_rdata : 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Output pins, registered copy of the latches
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         group_a_out <= 16'h0000;
         group_b_out <= 16'h0000;
         group_c_out <= 16'h0000;
      end
      else
      begin
         group_a_out <= {lat[1], lat[0]};
         group_b_out <= {lat[3], lat[2]};
         group_c_out <= {lat[5], lat[4]};
      end
   end

endmodule : iolp_output_port
`default_nettype wire

// *** iolp_params.svh ***
// Constants for the isolated output latch port
`ifndef IOLP_PARAMS_SVH
`define IOLP_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets within the eight-byte window
// ------------------------------------------------------------
`define IOLP_OFF_GROUP_A_LOW   3'h0
`define IOLP_OFF_GROUP_A_HIGH  3'h1
`define IOLP_OFF_GROUP_B_LOW   3'h2
`define IOLP_OFF_UNUSED_THREE  3'h3
`define IOLP_OFF_GROUP_B_HIGH  3'h4
`define IOLP_OFF_GROUP_C_LOW   3'h5
`define IOLP_OFF_GROUP_C_HIGH  3'h6
`define IOLP_OFF_UNUSED_SEVEN  3'h7

// ------------------------------------------------------------
// Window geometry and reset values
// ------------------------------------------------------------
`define IOLP_WINDOW_BYTES      8
`define IOLP_WINDOW_BITS       3
`define IOLP_IO_ADDR_BITS      16
`define IOLP_LATCH_RESET       8'h00
`define IOLP_UNUSED_READ       8'h00
// Identity codes: arbitrary values
`define IOLP_CFG_VENDOR_ID     16'h1234
`define IOLP_CFG_DEVICE_ID     16'h5678

`endif

// *** iolp_pkg.sv ***
// Types for the isolated output latch port
package iolp_pkg;
   typedef logic [7:0] iolp_byte_t;
   typedef logic [2:0] iolp_offset_t;
endpackage : iolp_pkg

// *** iolp_byte_latch.sv ***
// One byte-wide output latch with readback
`timescale 1ns/10ps
`default_nettype none
`include "iolp_params.svh"

module iolp_byte_latch
(
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             wr_en,
   input  wire iolp_pkg::iolp_byte_t wr_data,
   output var  iolp_pkg::iolp_byte_t latch_q
);

   // ------------------------------------------------------------
   // Latch
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         latch_q <= `IOLP_LATCH_RESET;
      else if (wr_en)
         latch_q <= wr_data;
   end

endmodule : iolp_byte_latch
`default_nettype wire

// *** iolp_port_monitor.sv ***
// Checker for the isolated output latch port
`timescale 1ns/10ps
`default_nettype none
module iolp_port_monitor
#(parameter int ADDR_W = 16)
(
   input wire logic                 clk,
   input wire logic                 rst_b,
   input wire logic                 cfg_base_wr,
   input wire logic [ADDR_W-1:0]    cfg_base_data,
   input wire logic                 io_wr,
   input wire logic                 io_rd,
   input wire logic [ADDR_W-1:0]    io_addr,
   input wire iolp_pkg::iolp_byte_t io_wdata,
   input wire iolp_pkg::iolp_byte_t io_rdata,
   input wire logic                 io_hit,
   input wire logic [ADDR_W-1:0]    cfg_base_q,
   input wire logic [15:0]          group_a_out,
   input wire logic [15:0]          group_b_out,
   input wire logic [15:0]          group_c_out
);
   // ------
   // Checks
   // ------
   wire logic sel = (io_wr | io_rd) &
                    (io_addr[ADDR_W-1:3] == cfg_base_q[ADDR_W-1:3]);
   wire logic [2:0] off = io_addr[2:0];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Reset itself is the cause here, so it must not disable the check
   reset_clear_a: assert property (disable iff (1'b0) !rst_b |=>
      (group_a_out | group_b_out | group_c_out) == 16'h0000)
      else $error("outputs not cleared by reset");
   base_store_a: assert property (cfg_base_wr |=>
      cfg_base_q == {$past(cfg_base_data[ADDR_W-1:3]), 3'h0})
      else $error("base not stored");
   window_hit_a: assert property (sel |=> io_hit)
      else $error("window access missed");
   miss_quiet_a: assert property (!sel |=> !io_hit && io_rdata == 8'h00)
      else $error("miss answered");
   // Pins follow the latch one cycle later, so writes show two edges on
   wr_a_high_a: assert property (io_wr && sel && off == 3'h1 |-> ##2
      group_a_out[15:8] == $past(io_wdata, 2)) else $error("a high wrong");
   wr_b_high_a: assert property (io_wr && sel && off == 3'h4 |-> ##2
      group_b_out[15:8] == $past(io_wdata, 2)) else $error("b high wrong");
   wr_c_low_a: assert property (io_wr && sel && off == 3'h5 |-> ##2
      group_c_out[7:0] == $past(io_wdata, 2)) else $error("c low wrong");
   rd_back_a: assert property (io_rd && !io_wr && sel && off == 3'h2 |=>
      ##1 group_b_out[7:0] == $past(io_rdata))
      else $error("readback wrong");
   unused_rd_a: assert property (io_rd && sel && off[1:0] == 2'h3 |=>
      io_rdata == 8'h00) else $error("unused read not zero");
   unused_wr_a: assert property (io_wr && sel && off[1:0] == 2'h3 |=> ##1
      $stable({group_a_out, group_b_out, group_c_out}))
      else $error("unused write changed outputs");
   cover property (io_wr && sel && off == 3'h6);
   cover property (io_rd && sel && off == 3'h7);
   cover property (io_wr && !sel);
endmodule : iolp_port_monitor
bind iolp_output_port iolp_port_monitor #(.ADDR_W(ADDR_W)) u_mon (
   .clk(clk), .rst_b(rst_b), .cfg_base_wr(cfg_base_wr),
   .cfg_base_data(cfg_base_data), .io_wr(io_wr), .io_rd(io_rd),
   .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
   .io_hit(io_hit), .cfg_base_q(cfg_base_q), .group_a_out(group_a_out),
   .group_b_out(group_b_out), .group_c_out(group_c_out));
`default_nettype wire

// *** iolp_host_model.sv ***
// Host bus model issuing configuration and I/O byte cycles
`timescale 1ns/10ps
`default_nettype none
module iolp_host_model
(
   input  wire logic        clk,
   output var  logic        cfg_base_wr,
   output var  logic [15:0] cfg_base_data,
   output var  logic        io_wr,
   output var  logic        io_rd,
   output var  logic [15:0] io_addr,
   output var  logic [7:0]  io_wdata
);
   initial {cfg_base_wr, cfg_base_data, io_wr, io_rd, io_addr, io_wdata} = '0;
   // One-cycle strobe; strobes drop to zero, address and data lines show inverted values, never stale
   task automatic cyc(input logic w, r, c, input logic [15:0] a,
                      input logic [7:0] d);
      @(posedge clk);
      #1 {cfg_base_wr, io_wr, io_rd, io_addr, io_wdata} = {c, w, r, a, d};
      cfg_base_data = a;
      @(posedge clk);
      #1 {cfg_base_wr, io_wr, io_rd} = 3'h0;
      {cfg_base_data, io_addr, io_wdata} = {~a, ~a, ~d};
   endtask : cyc
endmodule : iolp_host_model
`default_nettype wire

// *** iolp_output_port_tb.sv ***
// Self-checking bench for the isolated output latch port
`timescale 1ns/10ps
`default_nettype none
`include "iolp_params.svh"
module iolp_output_port_tb;
   logic clk = 0, rst_b = 0, cw, wr, rd, hit;
   logic [15:0] cd, ad, vid, did, bq, ga, gb, gc, base;
   logic [7:0] wd, rdat, d, m [8], q [$];
   logic [31:0] x = 11605;
   int mismatches, n_checks, cyc_n;
   initial forever #4 clk = ~clk;
   iolp_host_model u_host (.clk(clk), .cfg_base_wr(cw), .cfg_base_data(cd),
      .io_wr(wr), .io_rd(rd), .io_addr(ad), .io_wdata(wd));
   iolp_output_port u_dut (.clk(clk), .rst_b(rst_b), .cfg_base_wr(cw),
      .cfg_base_data(cd), .io_wr(wr), .io_rd(rd), .io_addr(ad),
      .io_wdata(wd), .io_rdata(rdat), .io_hit(hit), .cfg_vendor_id(vid),
      .cfg_device_id(did), .cfg_base_q(bq), .group_a_out(ga),
      .group_b_out(gb), .group_c_out(gc));
   function automatic logic [31:0] rnd();
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : rnd
   task automatic chk(string n, logic [15:0] e, g);
      n_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   // Each hit takes the oldest note; a hit with none noted is a fault
   always @(negedge clk) if (hit === 1'b1)
      chk("io_rdata", q.size() ? {8'h00, q.pop_front()} : 16'hxxxx,
          {8'h00, rdat});
   always @(posedge clk)
   begin
      cyc_n <= cyc_n + 1;
      if (cyc_n > 3000)
      begin
         mismatches++;
         print_verdict();
      end
   end
   initial
   begin
      repeat (6) @(posedge clk);
      #1 rst_b = 1;
      chk("group_a_out", 16'h0000, ga);
      chk("cfg_vendor_id", `IOLP_CFG_VENDOR_ID, vid);
      chk("cfg_device_id", `IOLP_CFG_DEVICE_ID, did);
      for (int k = 0; k < 2; k++)
      begin
         base = k ? 16'hfff8 : 16'(rnd()) & 16'hfff8;
         u_host.cyc(0, 0, 1, base, 8'h00);
         chk("cfg_base_q", base, bq);
         for (int i = 0; i < 8; i++)
         begin
            d = 8'(rnd());
            m[i] = (i % 4 == 3) ? 8'h00 : d;
            q.push_back(8'h00);
            u_host.cyc(1, 0, 0, base + 16'(i), d);
         end
         for (int i = 0; i < 8; i++)
         begin
            q.push_back(m[i]);
            u_host.cyc(0, 1, 0, base + 16'(i), 8'h00);
         end
         u_host.cyc(1, 0, 0, base ^ 16'h0008, 8'hff);
         chk("group_a_out", {m[1], m[0]}, ga);
         chk("group_b_out", {m[4], m[2]}, gb);
         chk("group_c_out", {m[6], m[5]}, gc);
         $display("window test at %h done", base);
      end
      @(posedge clk);
      #1 rst_b = 0;
      @(posedge clk);
      #1 rst_b = 1;
      chk("group_b_out", 16'h0000, gb);
      chk("cfg_base_q", 16'h0000, bq);
      chk("hits_missing", 16'h0000, 16'(q.size()));
      $display("reset test done");
      print_verdict();
   end
endmodule : iolp_output_port_tb
`default_nettype wire
